// ==== src/pcc_pkg.sv ====
/*
 Package for the counter array control block: register offsets, field positions,
 reset values, divider ratios and the count source encoding.
 Assumes a byte addressed Avalon-MM slave with one 32-bit word per register.
*/
package pcc_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] PCC_CTRL_IDX = 8'hD8;
   localparam logic [7:0] PCC_MODE_IDX = 8'hD9;
   localparam logic [7:0] PCC_IRQ_STAT_IDX = 8'hE0;
   localparam logic [7:0] PCC_IRQ_CLR_IDX = 8'hE1;
   localparam logic [7:0] PCC_IRQ_EN_IDX = 8'hE2;
   localparam logic [7:0] PCC_COUNT_LO_IDX = 8'hE3;
   localparam logic [7:0] PCC_COUNT_HI_IDX = 8'hE4;
   localparam int PCC_ADDR_W = 10;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PCC_OVF_BIT = 7;
   localparam int PCC_RUN_BIT = 6;
   localparam int PCC_NMOD = 5;
   localparam int PCC_IDLE_BIT = 7;
   localparam int PCC_WDT_BIT = 6;
   localparam int PCC_SRC_HI_BIT = 2;
   localparam int PCC_SRC_LO_BIT = 1;
   localparam int PCC_OIE_BIT = 0;
   localparam logic [7:0] PCC_CTRL_IMPL = 8'hDF;
   localparam logic [7:0] PCC_MODE_IMPL = 8'hC7;
   localparam logic [7:0] PCC_RESET = 8'h00;
   // ****************************************************************
   // Sources and dividers
   // ****************************************************************
   typedef enum logic [1:0] {
      PCC_SRC_OSC12 = 2'b00,
      PCC_SRC_OSC4 = 2'b01,
      PCC_SRC_T0OVF = 2'b10,
      PCC_SRC_PIN = 2'b11
   } pcc_src_t;
   localparam int PCC_DIV_STD_SLOW = 12;
   localparam int PCC_DIV_DBL_SLOW = 6;
   localparam int PCC_DIV_STD_FAST = 4;
   localparam int PCC_DIV_DBL_FAST = 2;
   localparam int PCC_PIN_MIN_PERIOD = 8;
endpackage : pcc_pkg

// ==== src/pcc_divider.sv ====
/*
 Prescaler for the counter array: one cycle enable pulses at the selected rate.
 Assumes core_clk_i is the oscillator clock and the ratio is stable between uses.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_divider #(
   parameter int MAX_DIV = 12
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] ratio_i,
   output logic tick_o
);
   import pcc_pkg::*;
   logic [3:0] cnt_r;
   initial begin
      if (MAX_DIV < 2 || MAX_DIV > 15) $error("pcc_divider: MAX_DIV out of range");
   end
   // ****************************************************************
   // Modulo counter
   // ****************************************************************
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 4'h0;
      end else if (cnt_r >= ratio_i - 4'h1) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   assign tick_o = (cnt_r >= ratio_i - 4'h1);
endmodule : pcc_divider
`default_nettype wire

// ==== src/pcc_ctrl.sv ====
/*
 Counter array control: mode and control/flag registers, count source mux,
 idle gating, run control, overflow and module flags, interrupt status/enable.
 Assumes an Avalon-MM master on core_clk_i; module events and timer 0 overflow
 are one-cycle pulses from the same clock; the count pin is asynchronous.
*/
// Added by the designer: the Avalon-MM interface to the registers.
// Notes on behaviour
// - Idle gate 0 keeps counting in idle; 1 stops counting while idle.
// - Watchdog enable bit turns module 4 watchdog function on or off.
// - Rollover sets overflow flag and status bit 0; interrupt when overflow enable or status enable bit 0 is set.
// - Software sets run bit to start counter; clearing it stops counter.
// - Overflow flag set by hardware or software; cleared only by software write.
// - Bits 0-4 are module flags, hardware sets, only software clears.
// - Reserved bits should be written zero; they read as zero here.
`timescale 1ns/100ps
`default_nettype none
module pcc_ctrl #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [pcc_pkg::PCC_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic idle_mode_i,
   input wire logic double_speed_mode_i,
   input wire logic timer0_overflow_i,
   input wire logic external_count_pin_i,
   input wire logic [pcc_pkg::PCC_NMOD-1:0] module_event_i,
   output logic module4_watchdog_enable_o,
   output logic counter_tick_o,
   output logic [CNT_W-1:0] count_o,
   output logic irq_o
);
   import pcc_pkg::*;
   initial begin
      if (CNT_W < 2 || CNT_W > 16) $error("pcc_ctrl: CNT_W must be 2..16");
   end
   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic ack_r;
   logic [31:0] rdata_r;
   logic wr_ok;
   logic [7:0] idx;
   logic [7:0] wbyte;
   assign idx = avs_address_i[PCC_ADDR_W-1:2];
   assign wbyte = avs_writedata_i[7:0];
   // Write lands at the edge where waitrequest is seen low
   assign wr_ok = avs_write_i && ack_r && avs_byteenable_i[0];
   // One wait state per access, then a single acknowledge cycle
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      end
   end
   // ****************************************************************
   // Mode register
   // ****************************************************************
   logic [7:0] mode_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_r <= PCC_RESET;
      end else if (wr_ok && idx == PCC_MODE_IDX) begin
         mode_r <= wbyte & PCC_MODE_IMPL;
      end
   end
   assign module4_watchdog_enable_o = mode_r[PCC_WDT_BIT];
   // ****************************************************************
   // Count source
   // ****************************************************************
   logic [3:0] slow_ratio;
   logic [3:0] fast_ratio;
   logic slow_tick;
   logic fast_tick;
   logic pin_s1_r;
   logic pin_s2_r;
   logic pin_d_r;
   logic pin_edge;
   logic src_event;
   pcc_src_t src_sel;
   assign src_sel = pcc_src_t'({mode_r[PCC_SRC_HI_BIT], mode_r[PCC_SRC_LO_BIT]});
   assign slow_ratio = double_speed_mode_i ? 4'(PCC_DIV_DBL_SLOW) : 4'(PCC_DIV_STD_SLOW);
   assign fast_ratio = double_speed_mode_i ? 4'(PCC_DIV_DBL_FAST) : 4'(PCC_DIV_STD_FAST);
   pcc_divider #(.MAX_DIV(PCC_DIV_STD_SLOW)) u_div_slow (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .ratio_i(slow_ratio),
      .tick_o(slow_tick)
   );
   pcc_divider #(.MAX_DIV(PCC_DIV_STD_SLOW)) u_div_fast (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .ratio_i(fast_ratio),
      .tick_o(fast_tick)
   );
   // Pin passes two flops; falling edge counts, pin must stay under osc/8
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_d_r <= 1'b1;
      end else begin
         pin_s1_r <= external_count_pin_i;
         pin_s2_r <= pin_s1_r;
         pin_d_r <= pin_s2_r;
      end
   end
   assign pin_edge = pin_d_r && !pin_s2_r;
   always_comb begin
      unique case (src_sel)
         PCC_SRC_OSC12: src_event = slow_tick;
         PCC_SRC_OSC4: src_event = fast_tick;
         PCC_SRC_T0OVF: src_event = timer0_overflow_i;
         PCC_SRC_PIN: src_event = pin_edge;
      endcase
   end
   // ****************************************************************
   // Control/flag register and counter
   // ****************************************************************
   logic run_r;
   logic ovf_r;
   logic [PCC_NMOD-1:0] mflag_r;
   logic [CNT_W-1:0] count_r;
   logic gated;
   logic advance;
   logic rollover;
   logic ctrl_wr;
   assign ctrl_wr = wr_ok && idx == PCC_CTRL_IDX;
   assign gated = idle_mode_i && mode_r[PCC_IDLE_BIT];
   assign advance = run_r && !gated && src_event;
   assign rollover = advance && (&count_r);
   assign counter_tick_o = advance;
   assign count_o = count_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_r <= '0;
      end else if (advance) begin
         count_r <= count_r + 1'b1;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_r <= 1'b0;
      end else if (ctrl_wr) begin
         run_r <= wbyte[PCC_RUN_BIT];
      end
   end
   // Set wins over a clearing write in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ovf_r <= 1'b0;
      end else if (rollover) begin
         ovf_r <= 1'b1;
      end else if (ctrl_wr) begin
         ovf_r <= wbyte[PCC_OVF_BIT];
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < PCC_NMOD; gi++) begin : g_mflag
         always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               mflag_r[gi] <= 1'b0;
            end else if (module_event_i[gi]) begin
               mflag_r[gi] <= 1'b1;
            end else if (ctrl_wr && !wbyte[gi]) begin
               mflag_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   // ****************************************************************
   // Interrupt status, clear and enable
   // ****************************************************************
   // Status bit 0 rollover, bits 1-5 module events
   logic [PCC_NMOD:0] ist_r;
   logic [PCC_NMOD:0] ien_r;
   logic [PCC_NMOD:0] ev;
   logic [PCC_NMOD:0] clr;
   assign ev = {module_event_i, rollover};
   assign clr = (wr_ok && idx == PCC_IRQ_CLR_IDX) ? wbyte[PCC_NMOD:0] : '0;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ist_r <= '0;
      end else begin
         ist_r <= ev | (ist_r & ~clr);
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ien_r <= '0;
      end else if (wr_ok && idx == PCC_IRQ_EN_IDX) begin
         ien_r <= wbyte[PCC_NMOD:0];
      end
   end
   // Overflow flag reaches the line only with the mode register enable
   logic ovf_irq;
   assign ovf_irq = ovf_r && mode_r[PCC_OIE_BIT];
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= ovf_irq || |(ist_r & ien_r);
      end
   end
   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] ctrl_rd;
   logic [15:0] cnt_ext;
   assign ctrl_rd = {ovf_r, run_r, 1'b0, mflag_r};
   assign cnt_ext = 16'(count_r);
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read_i && !ack_r) begin
         unique case (idx)
            PCC_CTRL_IDX: rdata_r <= {24'h00_0000, ctrl_rd};
            PCC_MODE_IDX: rdata_r <= {24'h00_0000, mode_r};
            PCC_IRQ_STAT_IDX: rdata_r <= {26'h0, ist_r};
            PCC_IRQ_EN_IDX: rdata_r <= {26'h0, ien_r};
            PCC_COUNT_LO_IDX: rdata_r <= {24'h00_0000, cnt_ext[7:0]};
            PCC_COUNT_HI_IDX: rdata_r <= {24'h00_0000, cnt_ext[15:8]};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_readdata_o = rdata_r;
endmodule : pcc_ctrl
`default_nettype wire

// ==== verification/pcc_ctrl_sva.sv ====
/* Checker on the pcc_ctrl ports: bus timing, gating, counting, interrupt.
   Assumes the count registers are never written by software. */
`timescale 1ns/100ps
`default_nettype none
module pcc_ctrl_sva #(
   parameter int CNT_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [pcc_pkg::PCC_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic idle_mode_i,
   input wire logic timer0_overflow_i,
   input wire logic module4_watchdog_enable_o,
   input wire logic counter_tick_o,
   input wire logic [CNT_W-1:0] count_o,
   input wire logic irq_o
);
   import pcc_pkg::*;
   logic acc_w;
   logic [7:0] idx_w;
   logic run_r;
   logic [7:0] mode_r;
   logic [5:0] en_r;
   assign acc_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign idx_w = avs_address_i[9:2];
   // ****************************************************************
   // Shadow of software settings, taken at the accepting edge
   // ****************************************************************
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_r <= 1'b0;
         mode_r <= PCC_RESET;
         en_r <= 6'h00;
      end else if (acc_w) begin
         if (idx_w == PCC_CTRL_IDX) run_r <= avs_writedata_i[PCC_RUN_BIT];
         if (idx_w == PCC_MODE_IDX) mode_r <= avs_writedata_i[7:0];
         if (idx_w == PCC_IRQ_EN_IDX) en_r <= avs_writedata_i[5:0];
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_wdt_follows_write: assert property (acc_w && idx_w == PCC_MODE_IDX
      |=> module4_watchdog_enable_o == $past(avs_writedata_i[PCC_WDT_BIT]))
      else $error("watchdog enable wrong");
   chk_tick_adds_one: assert property (counter_tick_o
      |=> count_o == CNT_W'($past(count_o) + 1'b1)) else $error("count step wrong");
   chk_bus_two_cycles: assert property ($rose(avs_read_i || avs_write_i)
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus timing wrong");
   chk_run_gates_tick: assert property (!run_r |-> !counter_tick_o)
      else $error("tick while stopped");
   chk_idle_gates_tick: assert property (mode_r[PCC_IDLE_BIT] && idle_mode_i
      |-> !counter_tick_o) else $error("tick while idle gated");
   chk_timer0_counts: assert property (run_r && !idle_mode_i && timer0_overflow_i
      && mode_r[2:1] == PCC_SRC_T0OVF |-> ##[0:1] counter_tick_o)
      else $error("timer0 event not counted");
   chk_rollover_irq: assert property (counter_tick_o && &count_o && mode_r[PCC_OIE_BIT]
      |-> ##[1:3] irq_o) else $error("no irq on rollover");
   chk_irq_masked: assert property ((!mode_r[PCC_OIE_BIT] && en_r == 6'h00) [*3]
      |-> !irq_o) else $error("irq while masked");
   cover property (irq_o);
   cover property (counter_tick_o && &count_o);
   cover property (mode_r[PCC_IDLE_BIT] && idle_mode_i && run_r);
endmodule : pcc_ctrl_sva
bind pcc_ctrl pcc_ctrl_sva #(.CNT_W(CNT_W)) pcc_ctrl_sva_i (.core_clk_i, .rst_b_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_waitrequest_o, .idle_mode_i, .timer0_overflow_i, .module4_watchdog_enable_o,
   .counter_tick_o, .count_o, .irq_o);
`default_nettype wire

// ==== verification/pcc_pin_model.sv ====
/* External count pin driver with its pull-up.
   Assumes go_i is a one-cycle pulse on the core clock. */
`timescale 1ns/100ps
`default_nettype none
module pcc_pin_model (
   input wire logic core_clk_i,
   input wire logic go_i,
   output logic pin_o
);
   logic [2:0] low_r = 3'h0;
   // Low 4 cycles, then back to pull-up level; callers space pulses
   always @(posedge core_clk_i) begin
      if (go_i) low_r <= 3'h4;
      else if (low_r != 3'h0) low_r <= low_r - 3'h1;
   end
   assign pin_o = (low_r == 3'h0);
endmodule : pcc_pin_model
`default_nettype wire

// ==== verification/pcc_ctrl_tb.sv ====
/* Testbench for pcc_ctrl: sources, gating, flags and interrupts.
   Assumes pcc_pin_model drives the count pin; counter cut to 4 bits. */
`timescale 1ns/100ps
`default_nettype none
module pcc_ctrl_tb;
   import pcc_pkg::*;
   typedef struct {logic [7:0] m; logic [7:0] c; logic x; logic i; logic [15:0] n;} pcc_row_t;
   logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, wreq, idle = 1'b0, dbl = 1'b0;
   logic t0 = 1'b0, go = 1'b0, pin, wdt, tick, irq;
   logic [9:0] addr = '0;
   logic [31:0] wdat = '0, rdat;
   logic [4:0] mev = '0;
   logic [3:0] cnt, c;
   logic [7:0] r;
   logic [15:0] t;
   int miscompares = 0;
   int n_tests = 0;
   // Reserved bits always written as zero
   pcc_row_t rows[7] = '{'{8'h00, 8'h40, 0, 0, 16'h0002}, '{8'h00, 8'h40, 1, 0, 16'h0004},
      '{8'h02, 8'h40, 0, 0, 16'h0006}, '{8'h42, 8'h40, 1, 0, 16'h000C},
      '{8'h82, 8'h40, 1, 1, 16'h0000}, '{8'h02, 8'h40, 1, 1, 16'h000C},
      '{8'h02, 8'h00, 1, 0, 16'h0000}};
   pcc_ctrl #(.CNT_W(4)) pcc_ctrl_i (.core_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .idle_mode_i(idle),
      .double_speed_mode_i(dbl), .timer0_overflow_i(t0), .external_count_pin_i(pin),
      .module_event_i(mev), .module4_watchdog_enable_o(wdt), .counter_tick_o(tick),
      .count_o(cnt), .irq_o(irq));
   pcc_pin_model pcc_pin_model_i (.core_clk_i(clk), .go_i(go), .pin_o(pin));
   always #12.5 clk = ~clk;
   // ****************************************************************
   // Bus, compare and closing tasks
   // ****************************************************************
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= {idx, 2'b00};
      wdat <= {24'h00_0000, d};
      wr <= w;
      rd <= !w;
      // Waitrequest and read data seen as they stand before each edge
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      r = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         $display("BAD %0t bus timeout", $time);
      end
   endtask : bus
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      #(4000 * 25);
      miscompares++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         dbl <= rows[i].x;
         idle <= rows[i].i;
         bus(1'b1, PCC_MODE_IDX, rows[i].m);
         bus(1'b1, PCC_CTRL_IDX, rows[i].c);
         bus(1'b0, PCC_MODE_IDX, 8'h00);
         chk(r, rows[i].m);
         chk(wdt, rows[i].m[6]);
         repeat (20) @(negedge clk);
         t = '0;
         // Window is a whole number of periods, so the count is exact
         repeat (24) begin
            @(negedge clk);
            t += 16'(tick === 1'b1);
         end
         chk(t, rows[i].n);
         $display("row %0d done", i);
      end
      // Leave idle so timer 0 and pin events are not gated
      @(posedge clk);
      idle <= 1'b0;
      bus(1'b1, PCC_CTRL_IDX, 8'h40);
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, PCC_MODE_IDX, j ? 8'h06 : 8'h04);
         @(negedge clk);
         c = cnt;
         repeat (3) begin
            @(posedge clk);
            if (j) go <= 1'b1;
            else t0 <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            t0 <= 1'b0;
            repeat (10) @(posedge clk);
         end
         @(negedge clk);
         chk(cnt, 4'(c + 4'h3));
         bus(1'b0, PCC_COUNT_LO_IDX, 8'h00);
         chk(r, 4'(c + 4'h3));
      end
      bus(1'b0, PCC_COUNT_HI_IDX, 8'h00);
      chk(r, 8'h00);
      $display("event sources done");
      bus(1'b1, PCC_CTRL_IDX, 8'h00);
      bus(1'b1, PCC_MODE_IDX, 8'h03);
      bus(1'b1, PCC_CTRL_IDX, 8'h40);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk);
      chk(irq, 1'b1);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'hC0);
      bus(1'b1, PCC_CTRL_IDX, 8'h80);
      bus(1'b1, PCC_MODE_IDX, 8'h02);
      repeat (30) @(negedge clk);
      chk(irq, 1'b0);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h80);
      bus(1'b1, PCC_CTRL_IDX, 8'h00);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h00);
      bus(1'b1, PCC_CTRL_IDX, 8'h80);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h80);
      bus(1'b1, PCC_CTRL_IDX, 8'h00);
      $display("rollover done");
      @(posedge clk);
      mev <= 5'h15;
      @(posedge clk);
      mev <= 5'h00;
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h15);
      bus(1'b1, PCC_CTRL_IDX, 8'h1F);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h15);
      bus(1'b1, PCC_CTRL_IDX, 8'h00);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h00);
      bus(1'b0, PCC_IRQ_STAT_IDX, 8'h00);
      chk(r, 8'h2B);
      bus(1'b1, PCC_IRQ_EN_IDX, 8'h02);
      repeat (3) @(negedge clk);
      chk(irq, 1'b1);
      bus(1'b1, PCC_IRQ_CLR_IDX, 8'h3F);
      repeat (3) @(negedge clk);
      chk(irq, 1'b0);
      bus(1'b0, PCC_IRQ_STAT_IDX, 8'h00);
      chk(r, 8'h00);
      bus(1'b1, 8'h10, 8'hFF);
      bus(1'b0, 8'h10, 8'h00);
      chk(r, 8'h00);
      $display("flags and interrupts done");
      // Mid-run reset with run, overflow, watchdog and overflow enable bits set
      bus(1'b1, PCC_MODE_IDX, 8'h41);
      bus(1'b1, PCC_CTRL_IDX, 8'hC0);
      repeat (3) @(negedge clk);
      chk(irq, 1'b1);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk(wdt, 1'b0);
      chk(irq, 1'b0);
      chk(cnt, 4'h0);
      bus(1'b0, PCC_CTRL_IDX, 8'h00);
      chk(r, 8'h00);
      bus(1'b0, PCC_MODE_IDX, 8'h00);
      chk(r, 8'h00);
      $display("reset done");
      stop_test();
   end
endmodule : pcc_ctrl_tb
`default_nettype wire
